// ===== include/ext_irq_pkg.sv
// Shared constants and types for the external pin interrupt unit.
// Assumes a single 20 MHz bus clock and an AXI4-Lite register port.
package ext_irq_pkg;

    // Clock and pulse timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_INT_NS = 50;
    localparam int MIN_PULSE_CYC = (T_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Number of lines and bus geometry
    localparam int NUM_LINES = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_SENSE_SYS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_EXT_SENSE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PIN_STATE = 8'h10;

    // Reset values
    localparam logic [REG_W-1:0] RST_SENSE_SYS = 8'h00;
    localparam logic [REG_W-1:0] RST_EXT_SENSE = 8'h00;
    localparam logic [REG_W-1:0] RST_ENABLE = 8'h00;

    // Field positions
    localparam int POS_L1_SENSE_LO = 2;
    localparam int POS_L0_SENSE_LO = 0;
    localparam int POS_L2_EDGE_SEL = 0;
    localparam int POS_EN_L1 = 7;
    localparam int POS_EN_L0 = 6;
    localparam int POS_EN_L2 = 5;
    localparam logic [REG_W-1:0] ENABLE_WMASK = 8'he3;
    localparam int POS_FLAG_L1 = 7;
    localparam int POS_FLAG_L0 = 6;
    localparam int POS_FLAG_L2 = 5;

    // Sense encodings
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Wake sampling
    localparam int WDT_SAMPLES = 2;
    localparam int STARTUP_CYC_DEF = 64;

    // Per-line trigger setup
    typedef struct packed {
        logic [1:0] sense;
        logic detect_en;
    } line_cfg_t;

    // Per-line sampled state
    typedef struct packed {
        logic level;
        logic event_p;
    } line_obs_t;

    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_SAMPLING,
        WAKE_STARTUP
    } wake_state_t;

endpackage

// ===== hw/ext_irq_edge_cell.sv
// One interrupt line: pin synchroniser and edge or change detector.
// Assumes the pin is asynchronous to aclk; the caller supplies sense and gating.
`timescale 1ns/1ps
module ext_irq_edge_cell
    import ext_irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    input line_cfg_t cfg,
    output line_obs_t obs
);

    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic hit;

    // Two-stage synchroniser; only sync_r and beyond feed logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edges judged on sampled value, so one full period is enough
    always_comb begin
        case (cfg.sense)
            SENSE_ANY: hit = sync_r ^ prev_r;
            SENSE_FALL: hit = prev_r & ~sync_r;
            SENSE_RISE: hit = ~prev_r & sync_r;
            default: hit = 1'b0;
        endcase
    end

    // Event pulse registered so data output comes from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Level resets to the pulled-up idle state, as the synchroniser does
            obs.level <= 1'b1;
            obs.event_p <= 1'b0;
        end else begin
            obs.level <= sync_r;
            obs.event_p <= hit & cfg.detect_en;
        end
    end

endmodule // ext_irq_edge_cell

// ===== hw/external_pin_interrupt_unit.sv
// External pin interrupt unit: three lines, sense control, flags, wake.
// Assumes AXI4-Lite master on aclk, pins asynchronous, wdt_tick on aclk.
//
// Notes on behaviour
// - Pin activity triggers even when pin drives out
// - Line two is edge only, never level
// - Level mode requests while pin stays low
// - Lines zero/one edges need running I/O clock
// - Level and line-two edge wake without I/O clock
// - Level wake needs two watchdog-tick low samples
// - Level gone after startup: wake, no interrupt
// - Line one sense: low, change, fall, rise
// - Line zero sense uses same encoding
// - Pins synchronised before edge detection
// - Pulses over one clock trigger on line two, and on lines zero/one while I/O clock runs
// - Request needs global enable and line enable
// - Line two select: zero falling, one rising
// - Line two pulses over minimum width trigger
// - Enable bits 7,6,5; bits 4..2 read zero
// - Flag set on event, cleared by ack/one
// - Flags at bits 7,6,5 of flag register
// - Flag reads zero in level mode
`timescale 1ns/1ps
module external_pin_interrupt_unit
    import ext_irq_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_LINES-1:0] ext_line_pin,
    input wire logic global_irq_enable,
    input wire logic io_clock_running,
    input wire logic wdt_tick,
    input wire logic [NUM_LINES-1:0] irq_ack,
    output logic [NUM_LINES-1:0] irq_req,
    output logic wake_req
);

    localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

    // Software registers
    logic [REG_W-1:0] sense_and_system_control_r;
    logic [REG_W-1:0] extended_sense_control_r;
    logic [REG_W-1:0] interrupt_enable_control_r;
    logic [NUM_LINES-1:0] pending_r;

    // Bus slave state
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W/8-1:0] wstrb_r;
    logic do_write;
    logic wr_hit;

    // Line decode
    logic [1:0] sense [NUM_LINES];
    logic [NUM_LINES-1:0] line_en;
    logic [NUM_LINES-1:0] level_mode;
    logic [NUM_LINES-1:0] pin_level;
    logic [NUM_LINES-1:0] pin_event;
    logic [NUM_LINES-1:0] w1c_clear;
    line_cfg_t cfg [NUM_LINES];
    line_obs_t obs [NUM_LINES];

    // Wake logic
    wake_state_t wake_state_r;
    wake_state_t wake_state_nxt;
    logic [CNT_W-1:0] startup_cnt_r;
    logic [1:0] wdt_low_cnt_r;
    logic level_wake_low;

    // Sense fields; line two is forced to an edge code
    always_comb begin
        sense[0] = sense_and_system_control_r[POS_L0_SENSE_LO +: 2];
        sense[1] = sense_and_system_control_r[POS_L1_SENSE_LO +: 2];
        sense[2] = {1'b1, extended_sense_control_r[POS_L2_EDGE_SEL]};
        line_en[0] = interrupt_enable_control_r[POS_EN_L0];
        line_en[1] = interrupt_enable_control_r[POS_EN_L1];
        line_en[2] = interrupt_enable_control_r[POS_EN_L2];
    end

    // Line cells; pins read directly, so output direction does not matter
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            // Line two keeps detecting with I/O clock stopped
            assign cfg[gi].sense = sense[gi];
            assign cfg[gi].detect_en = (gi == 2) ? 1'b1 : io_clock_running;
            assign level_mode[gi] = (gi != 2) && (sense[gi] == SENSE_LOW);
            assign pin_level[gi] = obs[gi].level;
            assign pin_event[gi] = obs[gi].event_p;
            ext_irq_edge_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin(ext_line_pin[gi]),
                .cfg(cfg[gi]),
                .obs(obs[gi])
            );
        end
    endgenerate

    // Write-one-to-clear decode of the flag register
    always_comb begin
        w1c_clear = '0;
        if (do_write && awaddr_r == OFF_FLAGS && wstrb_r[0]) begin
            w1c_clear[0] = wdata_r[POS_FLAG_L0];
            w1c_clear[1] = wdata_r[POS_FLAG_L1];
            w1c_clear[2] = wdata_r[POS_FLAG_L2];
        end
    end

    // Pending flags; a new event beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_r <= '0;
        end else begin
            for (int i = 0; i < NUM_LINES; i++) begin
                if (level_mode[i]) begin
                    pending_r[i] <= 1'b0;
                end else if (pin_event[i]) begin
                    pending_r[i] <= 1'b1;
                end else if (irq_ack[i] || w1c_clear[i]) begin
                    pending_r[i] <= 1'b0;
                end
            end
        end
    end

    // Requests to vector logic; level held back while starting up
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            if (level_mode[i]) begin
                irq_req[i] = ~pin_level[i] && line_en[i] && global_irq_enable
                    && wake_state_r != WAKE_STARTUP;
            end else begin
                irq_req[i] = pending_r[i] && line_en[i] && global_irq_enable;
            end
        end
    end

    // Any enabled level line currently low
    assign level_wake_low = |(level_mode & line_en & ~pin_level);

    // Wake sequencer: double watchdog sample, then startup wait
    always_comb begin
        wake_state_nxt = wake_state_r;
        case (wake_state_r)
            WAKE_IDLE: begin
                if (!io_clock_running && level_wake_low) begin
                    wake_state_nxt = WAKE_SAMPLING;
                end
            end
            WAKE_SAMPLING: begin
                if (!level_wake_low) begin
                    wake_state_nxt = WAKE_IDLE;
                end else if (wdt_tick && wdt_low_cnt_r == 2'(WDT_SAMPLES - 1)) begin
                    wake_state_nxt = WAKE_STARTUP;
                end
            end
            WAKE_STARTUP: begin
                if (startup_cnt_r == CNT_W'(STARTUP_CYCLES - 1)) begin
                    wake_state_nxt = WAKE_IDLE;
                end
            end
            default: wake_state_nxt = WAKE_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_state_r <= WAKE_IDLE;
        end else begin
            wake_state_r <= wake_state_nxt;
        end
    end

    // Watchdog sample count, restarts on leaving sampling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_low_cnt_r <= '0;
        end else if (wake_state_r != WAKE_SAMPLING) begin
            wdt_low_cnt_r <= '0;
        end else if (wdt_tick) begin
            wdt_low_cnt_r <= wdt_low_cnt_r + 2'h1;
        end
    end

    // Startup timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            startup_cnt_r <= '0;
        end else if (wake_state_r == WAKE_STARTUP) begin
            startup_cnt_r <= startup_cnt_r + CNT_W'(1);
        end else begin
            startup_cnt_r <= '0;
        end
    end

    // Wake pulse: level wake after sampling, or an enabled line-two edge while the I/O clock is stopped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= (wake_state_r == WAKE_SAMPLING && wake_state_nxt == WAKE_STARTUP)
                || (!io_clock_running && pin_event[2] && line_en[2]);
        end
    end

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r;
    assign wr_hit = awaddr_r == OFF_SENSE_SYS || awaddr_r == OFF_EXT_SENSE
        || awaddr_r == OFF_ENABLE || awaddr_r == OFF_FLAGS || awaddr_r == OFF_PIN_STATE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_and_system_control_r <= RST_SENSE_SYS;
            extended_sense_control_r <= RST_EXT_SENSE;
            interrupt_enable_control_r <= RST_ENABLE;
        end else if (do_write && wstrb_r[0]) begin
            if (awaddr_r == OFF_SENSE_SYS) begin
                sense_and_system_control_r <= wdata_r[REG_W-1:0];
            end else if (awaddr_r == OFF_EXT_SENSE) begin
                extended_sense_control_r <= wdata_r[REG_W-1:0];
            end else if (awaddr_r == OFF_ENABLE) begin
                interrupt_enable_control_r <= wdata_r[REG_W-1:0] & ENABLE_WMASK;
            end
        end
    end

    // Read channel: one read at a time, answer the cycle after
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            if (s_axi_araddr == OFF_SENSE_SYS) begin
                s_axi_rdata[REG_W-1:0] <= sense_and_system_control_r;
            end else if (s_axi_araddr == OFF_EXT_SENSE) begin
                s_axi_rdata[REG_W-1:0] <= extended_sense_control_r;
            end else if (s_axi_araddr == OFF_ENABLE) begin
                s_axi_rdata[REG_W-1:0] <= interrupt_enable_control_r;
            end else if (s_axi_araddr == OFF_FLAGS) begin
                s_axi_rdata[POS_FLAG_L1] <= pending_r[1];
                s_axi_rdata[POS_FLAG_L0] <= pending_r[0];
                s_axi_rdata[POS_FLAG_L2] <= pending_r[2];
            end else if (s_axi_araddr == OFF_PIN_STATE) begin
                s_axi_rdata[NUM_LINES-1:0] <= pin_level;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    chk_edge_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_event[0] && !level_mode[0] |=> pending_r[0])
        else $error("line zero event did not set its flag");
    chk_level_flag_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        level_mode[1] |=> !pending_r[1] || !level_mode[1])
        else $error("line one flag set in level mode");
    chk_req_needs_gie: assert property (@(posedge aclk) disable iff (!aresetn)
        !global_irq_enable |-> irq_req == '0)
        else $error("request without global enable");
    chk_level_request: assert property (@(posedge aclk) disable iff (!aresetn)
        level_mode[0] && !pin_level[0] && line_en[0] && global_irq_enable
        && wake_state_r == WAKE_IDLE |-> irq_req[0])
        else $error("low level not requesting");
    chk_no_sleep_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        !io_clock_running [*2] |-> !pin_event[0] && !pin_event[1])
        else $error("edge seen with I/O clock stopped");
    chk_enable_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        interrupt_enable_control_r[4:2] == 3'h0)
        else $error("reserved enable bits nonzero");
    chk_line2_edge_only: assert property (@(posedge aclk) disable iff (!aresetn)
        pending_r[2] && line_en[2] && global_irq_enable |-> irq_req[2])
        else $error("line two not edge flag driven");
    chk_wake_two_ticks: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(wake_state_r == WAKE_STARTUP) |-> $past(wdt_tick) && $past(wdt_low_cnt_r) == 2'h1)
        else $error("wake without two watchdog samples");
    chk_startup_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_state_r == WAKE_STARTUP |-> !(irq_req[0] && level_mode[0]))
        else $error("level request during startup");
    chk_ack_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_ack[1] && !pin_event[1] |=> !pending_r[1])
        else $error("acknowledge did not clear flag");

endmodule // external_pin_interrupt_unit

// ===== tb/ext_pin_model.sv
// Far-side model: board sources on the three external interrupt pins.
// Assumes pulled-up lines and changes made just after aclk rises.
`timescale 1ns/1ps
module ext_pin_model
    import ext_irq_pkg::*;
(
    input wire logic aclk,
    output logic [NUM_LINES-1:0] pins
);
    // Lines rest high until a source pulls them low
    initial begin
        pins = '1;
    end

    // Level is seen whoever drives it, as with a pin looped back from an output
    // A level stays until the next call, so a low is held long enough
    task automatic drive(input int idx, input logic lvl);
        begin
            @(posedge aclk);
            pins[idx] <= lvl;
        end
    endtask

    // Low pulse lasting cyc whole periods, never a sub-clock glitch
    task automatic pulse_low(input int idx, input int cyc);
        begin
            drive(idx, 1'b0);
            repeat (cyc) @(posedge aclk);
            pins[idx] <= 1'b1;
        end
    endtask
endmodule // ext_pin_model

// ===== tb/external_pin_interrupt_unit_test.sv
// Bench for the external pin interrupt unit: registers, edges, level, wake.
// Assumes the pin model owns the pins; the bench drives bus and core inputs.
`timescale 1ns/1ps
module external_pin_interrupt_unit_test
    import ext_irq_pkg::*;
();
    // Short startup keeps the wake case brief but longer than the pin sync
    localparam int STARTUP = 16;
    logic aclk;
    logic aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [NUM_LINES-1:0] pin, irq_ack, irq_req;
    logic gie, io_run, wdt_tick, wake_req;
    int miscompares, check_count, cycles, wake_cnt, n;

    external_pin_interrupt_unit #(.STARTUP_CYCLES(STARTUP)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_line_pin(pin), .global_irq_enable(gie), .io_clock_running(io_run),
        .wdt_tick(wdt_tick), .irq_ack(irq_ack), .irq_req(irq_req), .wake_req(wake_req)
    );
    ext_pin_model pins (.aclk(aclk), .pins(pin));

    // Clock, cycle ceiling and wake pulse count
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        wake_cnt <= wake_cnt + (wake_req === 1'b1);
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            check_count++;
            if (got !== exp) begin
                miscompares++;
                $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask

    // Address and data offered together; each released once taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        begin
            aw_done = 1'b0;
            w_done = 1'b0;
            @(posedge aclk);
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= {24'h0, d};
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(aw_done && w_done)) begin
                @(posedge aclk);
                if (!aw_done && awready === 1'b1) begin
                    aw_done = 1'b1;
                    awvalid <= 1'b0;
                end
                if (!w_done && wready === 1'b1) begin
                    w_done = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            while (bvalid !== 1'b1) @(posedge aclk);
            bready <= 1'b0;
            check(32'(bresp), 32'(er), "write response");
        end
    endtask

    task automatic rdx(input logic [ADDR_W-1:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge aclk); while (arready !== 1'b1);
            arvalid <= 1'b0;
            while (rvalid !== 1'b1) @(posedge aclk);
            rd = rdata;
            rsp = rresp;
            rready <= 1'b0;
        end
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        begin
            rdx(a);
            check(rd, {24'h0, exp}, "read data");
            check(32'(rsp), 32'(RESP_OKAY), "read response");
        end
    endtask

    task automatic tick();
        begin
            @(posedge aclk);
            wdt_tick <= 1'b1;
            @(posedge aclk);
            wdt_tick <= 1'b0;
        end
    endtask

    task automatic t_regs();
        begin
            rd_chk(OFF_SENSE_SYS, 8'h00);
            rd_chk(OFF_EXT_SENSE, 8'h00);
            rd_chk(OFF_ENABLE, 8'h00);
            rd_chk(OFF_FLAGS, 8'h00);
            wr(OFF_ENABLE, 8'hff, RESP_OKAY);
            rd_chk(OFF_ENABLE, 8'he3);
            wr(OFF_ENABLE, 8'h00, RESP_OKAY);
            wr(8'h14, 8'h5a, RESP_SLVERR);
            rdx(8'h14);
            check(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
            check(rd, 32'h0, "unmapped data");
            $display("regs done");
        end
    endtask

    // Every edge code on both lines, each direction of change
    task automatic t_edges();
        logic e;
        int p;
        begin
            gie <= 1'b1;
            wr(OFF_ENABLE, 8'hc0, RESP_OKAY);
            for (int l = 0; l < 2; l++) begin
                p = l ? POS_FLAG_L1 : POS_FLAG_L0;
                for (int m = 1; m < 4; m++) begin
                    wr(OFF_SENSE_SYS, 8'(m << (2 * l)), RESP_OKAY);
                    for (int v = 0; v < 2; v++) begin
                        pins.drive(l, v[0]);
                        repeat (6) @(posedge aclk);
                        e = v ? (m != 2) : (m != 3);
                        check(32'(irq_req[l]), 32'(e), "edge request");
                        rd_chk(OFF_FLAGS, 8'(e) << p);
                        // Change mode clears by vector acknowledge, the others by write-one
                        if (m == 1) begin
                            irq_ack[l] <= 1'b1;
                            @(posedge aclk);
                            irq_ack[l] <= 1'b0;
                        end
                        wr(OFF_FLAGS, 8'he0, RESP_OKAY);
                        rd_chk(OFF_FLAGS, 8'h00);
                    end
                end
            end
            $display("edges done");
        end
    endtask

    task automatic t_level();
        begin
            wr(OFF_SENSE_SYS, 8'h00, RESP_OKAY);
            wr(OFF_ENABLE, 8'h40, RESP_OKAY);
            pins.drive(0, 1'b0);
            repeat (6) @(posedge aclk);
            check(32'(irq_req), 32'h1, "level request");
            rd_chk(OFF_PIN_STATE, 8'h06);
            rd_chk(OFF_FLAGS, 8'h00);
            check(32'(irq_req), 32'h1, "level held");
            gie <= 1'b0;
            repeat (2) @(posedge aclk);
            check(32'(irq_req), 32'h0, "global mask");
            gie <= 1'b1;
            wr(OFF_ENABLE, 8'h00, RESP_OKAY);
            check(32'(irq_req), 32'h0, "line mask");
            pins.drive(0, 1'b1);
            $display("level done");
        end
    endtask

    task automatic t_line2();
        begin
            wr(OFF_ENABLE, 8'h20, RESP_OKAY);
            pins.pulse_low(2, 2);
            repeat (6) @(posedge aclk);
            check(32'(irq_req), 32'h4, "falling request");
            irq_ack <= 3'b100;
            @(posedge aclk);
            irq_ack <= 3'b000;
            repeat (2) @(posedge aclk);
            rd_chk(OFF_FLAGS, 8'h00);
            // Edge reselect with the line masked, stale flag cleared after it and before unmasking
            wr(OFF_ENABLE, 8'h00, RESP_OKAY);
            wr(OFF_EXT_SENSE, 8'h01, RESP_OKAY);
            wr(OFF_FLAGS, 8'h20, RESP_OKAY);
            wr(OFF_ENABLE, 8'h20, RESP_OKAY);
            pins.drive(2, 1'b0);
            repeat (6) @(posedge aclk);
            check(32'(irq_req), 32'h0, "low is no trigger");
            pins.drive(2, 1'b1);
            repeat (6) @(posedge aclk);
            rd_chk(OFF_FLAGS, 8'h20);
            wr(OFF_ENABLE, 8'h00, RESP_OKAY);
            $display("line2 done");
        end
    endtask

    // Sleep: line 0 edges ignored, line 2 edge wakes, level needs two samples
    task automatic t_sleep();
        begin
            io_run <= 1'b0;
            wr(OFF_SENSE_SYS, 8'h02, RESP_OKAY);
            wr(OFF_EXT_SENSE, 8'h00, RESP_OKAY);
            wr(OFF_FLAGS, 8'he0, RESP_OKAY);
            wr(OFF_ENABLE, 8'h60, RESP_OKAY);
            pins.pulse_low(0, 2);
            repeat (6) @(posedge aclk);
            rd_chk(OFF_FLAGS, 8'h00);
            n = wake_cnt;
            pins.pulse_low(2, 2);
            repeat (6) @(posedge aclk);
            check(32'(wake_cnt - n), 32'h1, "edge wake");
            rd_chk(OFF_FLAGS, 8'h20);
            wr(OFF_FLAGS, 8'h20, RESP_OKAY);
            wr(OFF_SENSE_SYS, 8'h00, RESP_OKAY);
            wr(OFF_ENABLE, 8'h40, RESP_OKAY);
            n = wake_cnt;
            pins.drive(0, 1'b0);
            repeat (6) @(posedge aclk);
            tick();
            repeat (3) @(posedge aclk);
            check(32'(wake_cnt - n), 32'h0, "one sample");
            tick();
            repeat (3) @(posedge aclk);
            check(32'(wake_cnt - n), 32'h1, "two samples");
            check(32'(irq_req), 32'h0, "startup mask");
            pins.drive(0, 1'b1);
            repeat (STARTUP + 6) @(posedge aclk);
            check(32'(irq_req), 32'h0, "level gone");
            check(32'(wake_cnt - n), 32'h1, "single wake");
            io_run <= 1'b1;
            $display("sleep done");
        end
    endtask

    // Inputs at time zero, reset for two cycles, then the cases in turn
    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        {irq_ack, gie, wdt_tick} = '0;
        io_run = 1'b1;
        {miscompares, check_count, cycles, wake_cnt} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_edges();
        t_level();
        t_line2();
        t_sleep();
        finish_test();
    end
endmodule // external_pin_interrupt_unit_test
